// ---- verilog/dtc_timer_ctrl.sv ----
// timer 0/1 control, mode and counting logic with ext irq flags
// assumes sfr requests, vector acks and config come from ref_clk logic
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_timer_ctrl
    import dtc_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // register access
    input wire dtc_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    // interrupt vectoring and outside settings
    input wire dtc_vec_s vec_ack,
    input wire dtc_cfg_s cfg,
    // pins
    input wire logic timer0_count_pin,
    input wire logic timer1_count_pin,
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    input wire logic ext_clk_in,
    // status
    output logic [7:0] timer_control_status,
    output logic [7:0] timer_mode_select,
    output logic timer0_overflow_tick,
    output logic timer1_overflow_tick
);
    logic [7:0] timer_control_status_q, timer_control_status_d, timer_mode_select_q;
    logic [7:0] tl0_q, th0_q, tl1_q, th1_q;
    logic [7:0] rdata_q;
    logic t0_tick_q, t1_tick_q;
    logic [5:0] div_cnt_q;
    logic [2:0] ext_cnt_q;
    logic [4:0] lvl, rise, fall;
    logic [5:0] div_lim;
    logic sys_tick, ext_tick, pre_tick;
    logic ext_irq0_input_act, ext_irq1_input_act, ext_irq0_input_edge, ext_irq1_input_edge;
    logic run_en0, run_en1, int_tick0, int_tick1, src0, src1;
    logic t0split, t1_active, t0_cnt, th0_cnt, t1_cnt;
    logic t0_ovf, th0_ovf, t1_ovf, tf1_set;
    logic [16:0] step0, step1;
    logic [8:0] th0_step;
    logic [7:0] wmask, wval, vclr, hwset;
    logic wr_timer_control_status, wr_timer_mode_select, wr_tl0, wr_th0, wr_tl1, wr_th1, bit_timer_control_status;
    dtc_mode_e mode0, mode1;

    // one step of a counter: {overflow, high byte, low byte}
    function automatic logic [16:0] dtc_step(input dtc_mode_e m,
        input logic [7:0] hi, input logic [7:0] lo);
        logic [12:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {hi, lo[4:0]} + 13'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        unique case (m)
            dtc_mode_13bit: return {&{hi, lo[4:0]}, s13[12:5], lo[7:5],
                s13[4:0]};
            dtc_mode_16bit: return s16;
            dtc_mode_auto8: return {s8[8], hi,
                s8[8] ? hi : s8[7:0]};
            dtc_mode_split: return {s8[8], hi, s8[7:0]};
        endcase
    endfunction

    // pins: t0, t1, ext_irq0_input, ext_irq1_input, external clock
    dtc_pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .ce(ce),
        .pin_in({ext_clk_in, ext_irq1_input, ext_irq0_input,
            timer1_count_pin, timer0_count_pin}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // address decode
    assign wr_timer_control_status = sfr_req.wr && sfr_req.addr == `DTC_TIMER_CONTROL_STATUS_ADDR;
    assign wr_timer_mode_select = sfr_req.wr && sfr_req.addr == `DTC_TIMER_MODE_SELECT_ADDR;
    assign wr_tl0 = sfr_req.wr && sfr_req.addr == `DTC_TL0_ADDR;
    assign wr_th0 = sfr_req.wr && sfr_req.addr == `DTC_TH0_ADDR;
    assign wr_tl1 = sfr_req.wr && sfr_req.addr == `DTC_TL1_ADDR;
    assign wr_th1 = sfr_req.wr && sfr_req.addr == `DTC_TH1_ADDR;
    // bit addresses 0x88..0x8F reach the control bits singly
    assign bit_timer_control_status = sfr_req.bit_wr &&
        sfr_req.addr[7:3] == 5'(`DTC_TIMER_CONTROL_STATUS_ADDR >> 3);

    // prescaler
    always_comb begin
        unique case (dtc_pre_e'(cfg.prescale_select))
            dtc_pre_div12: div_lim = `DTC_DIV_SYS12;
            dtc_pre_div4: div_lim = `DTC_DIV_SYS4;
            dtc_pre_div48: div_lim = `DTC_DIV_SYS48;
            dtc_pre_ext8: div_lim = `DTC_DIV_SYS12;
        endcase
    end
    assign sys_tick = div_cnt_q >= div_lim - 6'd1;
    assign ext_tick = rise[4] && ext_cnt_q == `DTC_DIV_EXT8;
    assign pre_tick = dtc_pre_e'(cfg.prescale_select) == dtc_pre_ext8 ?
        ext_tick : sys_tick;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_cnt_q <= 6'h00;
        end else if (ce) begin
            div_cnt_q <= sys_tick ? 6'h00 : div_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ext_cnt_q <= 3'h0;
        end else if (ce && rise[4]) begin
            ext_cnt_q <= ext_cnt_q + 3'h1;
        end
    end

    // ext irq detection and gating
    assign ext_irq0_input_act = lvl[2] == cfg.ext_irq0_polarity;
    assign ext_irq1_input_act = lvl[3] == cfg.ext_irq1_polarity;
    assign ext_irq0_input_edge = cfg.ext_irq0_polarity ? rise[2] : fall[2];
    assign ext_irq1_input_edge = cfg.ext_irq1_polarity ? rise[3] : fall[3];

    assign mode0 = dtc_mode_e'(timer_mode_select_q[`DTC_T0MODE_HI:`DTC_T0MODE_LO]);
    assign mode1 = dtc_mode_e'(timer_mode_select_q[`DTC_T1MODE_HI:`DTC_T1MODE_LO]);
    assign t0split = mode0 == dtc_mode_split;
    assign t1_active = mode1 != dtc_mode_split;

    assign run_en0 = timer_control_status_q[`DTC_TR0_BIT] &&
        (!timer_mode_select_q[`DTC_TIMER0_GATE_BIT] || ext_irq0_input_act);
    assign run_en1 = timer_control_status_q[`DTC_TR1_BIT] &&
        (!timer_mode_select_q[`DTC_TIMER1_GATE_BIT] || ext_irq1_input_act);
    assign int_tick0 = cfg.timer0_clock_select || pre_tick;
    assign int_tick1 = cfg.timer1_clock_select || pre_tick;
    assign src0 = timer_mode_select_q[`DTC_CT0_BIT] ? fall[0] : int_tick0;
    assign src1 = timer_mode_select_q[`DTC_CT1_BIT] ? fall[1] : int_tick1;

    assign t0_cnt = run_en0 && src0;
    // split high half: internal clock only, run by timer1 run bit
    assign th0_cnt = t0split && timer_control_status_q[`DTC_TR1_BIT] && int_tick0;
    // timer1 beside a split timer0 runs on its mode, internal clock only
    assign t1_cnt = t1_active &&
        (t0split ? int_tick1 : run_en1 && src1);

    assign step0 = dtc_step(mode0, th0_q, tl0_q);
    assign step1 = dtc_step(mode1, th1_q, tl1_q);
    assign th0_step = {1'b0, th0_q} + 9'h001;
    assign t0_ovf = t0_cnt && step0[16];
    assign th0_ovf = th0_cnt && th0_step[8];
    assign t1_ovf = t1_cnt && step1[16];
    assign tf1_set = t0split ? th0_ovf : t1_ovf;

    // counters; a software write to a byte beats its count that cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tl0_q <= `DTC_COUNT_RESET;
        end else if (ce) begin
            if (wr_tl0) begin
                tl0_q <= sfr_req.wdata;
            end else if (t0_cnt) begin
                tl0_q <= step0[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            th0_q <= `DTC_COUNT_RESET;
        end else if (ce) begin
            if (wr_th0) begin
                th0_q <= sfr_req.wdata;
            end else if (th0_cnt) begin
                th0_q <= th0_step[7:0];
            end else if (!t0split && t0_cnt) begin
                th0_q <= step0[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tl1_q <= `DTC_COUNT_RESET;
            th1_q <= `DTC_COUNT_RESET;
        end else if (ce) begin
            if (wr_tl1) begin
                tl1_q <= sfr_req.wdata;
            end else if (t1_cnt) begin
                tl1_q <= step1[7:0];
            end
            if (wr_th1) begin
                th1_q <= sfr_req.wdata;
            end else if (t1_cnt) begin
                th1_q <= step1[15:8];
            end
        end
    end

    // control register: hardware set wins over any clear
    always_comb begin
        wmask = 8'h00;
        wval = 8'h00;
        if (wr_timer_control_status) begin
            wmask = 8'hFF;
            wval = sfr_req.wdata;
        end else if (bit_timer_control_status) begin
            wmask[sfr_req.addr[2:0]] = 1'b1;
            wval[sfr_req.addr[2:0]] = sfr_req.bit_val;
        end
        vclr = 8'h00;
        vclr[`DTC_TF1_BIT] = vec_ack.timer1_ack;
        vclr[`DTC_TF0_BIT] = vec_ack.timer0_ack;
        vclr[`DTC_IE1_BIT] = vec_ack.ext_irq1_ack &&
            timer_control_status_q[`DTC_IT1_BIT];
        vclr[`DTC_IE0_BIT] = vec_ack.ext_irq0_ack &&
            timer_control_status_q[`DTC_IT0_BIT];
        hwset = 8'h00;
        hwset[`DTC_TF1_BIT] = tf1_set;
        hwset[`DTC_TF0_BIT] = t0_ovf;
        hwset[`DTC_IE1_BIT] = timer_control_status_q[`DTC_IT1_BIT] ?
            ext_irq1_input_edge : ext_irq1_input_act;
        hwset[`DTC_IE0_BIT] = timer_control_status_q[`DTC_IT0_BIT] ?
            ext_irq0_input_edge : ext_irq0_input_act;
        timer_control_status_d = (timer_control_status_q & ~vclr & ~wmask) | (wval & wmask) | hwset;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            timer_control_status_q <= `DTC_TIMER_CONTROL_STATUS_RESET;
        end else if (ce) begin
            timer_control_status_q <= timer_control_status_d;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            timer_mode_select_q <= `DTC_TIMER_MODE_SELECT_RESET;
        end else if (ce && wr_timer_mode_select) begin
            timer_mode_select_q <= sfr_req.wdata;
        end
    end

    // read data and overflow ticks
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (ce && sfr_req.rd) begin
            unique case (sfr_req.addr)
                `DTC_TIMER_CONTROL_STATUS_ADDR: rdata_q <= timer_control_status_q;
                `DTC_TIMER_MODE_SELECT_ADDR: rdata_q <= timer_mode_select_q;
                `DTC_TL0_ADDR: rdata_q <= tl0_q;
                `DTC_TL1_ADDR: rdata_q <= tl1_q;
                `DTC_TH0_ADDR: rdata_q <= th0_q;
                `DTC_TH1_ADDR: rdata_q <= th1_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            t0_tick_q <= 1'b0;
            t1_tick_q <= 1'b0;
        end else if (ce) begin
            t0_tick_q <= t0_ovf;
            t1_tick_q <= t1_ovf;
        end
    end

    assign sfr_rdata = rdata_q;
    assign timer_control_status = timer_control_status_q;
    assign timer_mode_select = timer_mode_select_q;
    assign timer0_overflow_tick = t0_tick_q;
    assign timer1_overflow_tick = t1_tick_q;

    // checks
    a_tf0_on_ovf: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && t0_ovf |=> timer_control_status_q[`DTC_TF0_BIT] && t0_tick_q)
        else $error("timer0 overflow did not set its flag");

    a_tf1_on_ovf: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && tf1_set |=> timer_control_status_q[`DTC_TF1_BIT])
        else $error("timer1 overflow did not set its flag");

    a_tf1_vec_clear: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && vec_ack.timer1_ack && !tf1_set && !wr_timer_control_status && !bit_timer_control_status
        |=> !timer_control_status_q[`DTC_TF1_BIT])
        else $error("timer1 vectoring did not clear its flag");

    a_run_stop0: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && !timer_control_status_q[`DTC_TR0_BIT] && !wr_tl0 |=> $stable(tl0_q))
        else $error("timer0 low byte moved while stopped");

    a_timer1_gate_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && timer_mode_select_q[`DTC_TIMER1_GATE_BIT] && !ext_irq1_input_act && !t0split && !wr_tl1
        |=> $stable(tl1_q))
        else $error("timer1 counted with gate input inactive");

    a_reload_low: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && mode0 == dtc_mode_auto8 && t0_cnt && tl0_q == 8'hFF &&
        !wr_tl0 && !wr_th0
        |=> tl0_q == $past(th0_q) && $stable(th0_q))
        else $error("reload mode did not reload from high byte");

    a_edge_pend0: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && timer_control_status_q[`DTC_IT0_BIT] && ext_irq0_input_edge |=> timer_control_status_q[`DTC_IE0_BIT])
        else $error("ext irq0 edge did not pend");

    a_level_keep1: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && !timer_control_status_q[`DTC_IT1_BIT] && timer_control_status_q[`DTC_IE1_BIT] &&
        vec_ack.ext_irq1_ack && !wr_timer_control_status && !bit_timer_control_status
        |=> timer_control_status_q[`DTC_IE1_BIT])
        else $error("level ext irq1 flag cleared by vectoring");

    a_t1_inactive: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && !t1_active && !wr_tl1 && !wr_th1
        |=> $stable(tl1_q) && $stable(th1_q))
        else $error("timer1 counted in inactive mode");

    a_pin_once: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && fall[0] |=> !fall[0])
        else $error("count pin edge seen twice");

    a_timer_mode_select_write: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && wr_timer_mode_select |=> timer_mode_select_q == $past(sfr_req.wdata))
        else $error("mode register write lost");

    a_timer_control_status_read: assert property (
        @(posedge ref_clk) disable iff (reset)
        ce && sfr_req.rd && sfr_req.addr == `DTC_TIMER_CONTROL_STATUS_ADDR
        |=> sfr_rdata == $past(timer_control_status_q))
        else $error("control register read wrong");

    c_tf0_set: cover property (@(posedge ref_clk) disable iff (reset)
        ce && t0_ovf);
    c_split_tf1: cover property (@(posedge ref_clk) disable iff (reset)
        ce && th0_ovf);
    c_reload: cover property (@(posedge ref_clk) disable iff (reset)
        ce && mode1 == dtc_mode_auto8 && t1_ovf);
    c_edge_irq1: cover property (@(posedge ref_clk) disable iff (reset)
        ce && timer_control_status_q[`DTC_IT1_BIT] && ext_irq1_input_edge);
endmodule
`default_nettype wire

// ---- verilog/dtc_regs.svh ----
// register offsets, field positions, reset values and prescale counts
// for the dual timer control block; included by dtc_timer_ctrl
// Summary of operation
// - timer1 overflow (timer0 high byte overflow in split mode) sets control bit 7; software or timer1 vectoring clears it
// - timer0 overflow sets control bit 5; software or timer0 vectoring clears it
// - control bit 6 starts timer1 when set, stops it when cleared; beside split timer0 it runs timer0 high byte and timer1 runs free
// - control bit 4 starts timer0 when set, stops it when cleared
// - control bit 3 pends ext irq1; vectoring clears it only when edge typed
// - control bit 1 pends ext irq0; vectoring clears it only when edge typed
// - control bit 2 picks ext irq1 level (0) or edge (1) detection
// - control bit 0 picks ext irq0 level (0) or edge (1) detection
// - control register at 0x88, bit addressable, all bits writable, resets zero
// - timer1 gate set means counting also needs ext irq1 input active
// - timer0 gate set means counting also needs ext irq0 input active
// - timer1 counter select picks internal clock or count pin falling edges
// - timer0 counter select picks internal clock or count pin falling edges
// - timer1 mode: 13-bit, 16-bit, 8-bit reload, or inactive
// - timer0 mode: 13-bit, 16-bit, 8-bit reload, or two 8-bit halves
// - 13-bit mode counts high byte plus low five bits, overflows past 0x1FFF
// - reload mode counts low byte, reloads it from high byte on overflow
// - split mode high byte counts internally, run by timer1 run, sets timer1 flag
// - prescaler gives clock /12, /4, /48 or synchronised external clock /8
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_TIMER_CONTROL_STATUS_ADDR 8'h88
`define DTC_TIMER_MODE_SELECT_ADDR 8'h89
`define DTC_TL0_ADDR 8'h8A
`define DTC_TL1_ADDR 8'h8B
`define DTC_TH0_ADDR 8'h8C
`define DTC_TH1_ADDR 8'h8D

`define DTC_TIMER_CONTROL_STATUS_RESET 8'h00
`define DTC_TIMER_MODE_SELECT_RESET 8'h00
`define DTC_COUNT_RESET 8'h00

`define DTC_TF1_BIT 7
`define DTC_TR1_BIT 6
`define DTC_TF0_BIT 5
`define DTC_TR0_BIT 4
`define DTC_IE1_BIT 3
`define DTC_IT1_BIT 2
`define DTC_IE0_BIT 1
`define DTC_IT0_BIT 0

`define DTC_TIMER1_GATE_BIT 7
`define DTC_CT1_BIT 6
`define DTC_T1MODE_HI 5
`define DTC_T1MODE_LO 4
`define DTC_TIMER0_GATE_BIT 3
`define DTC_CT0_BIT 2
`define DTC_T0MODE_HI 1
`define DTC_T0MODE_LO 0

`define DTC_DIV_SYS12 6'd12
`define DTC_DIV_SYS4 6'd4
`define DTC_DIV_SYS48 6'd48
`define DTC_DIV_EXT8 3'h7

`endif

// ---- verilog/dtc_pkg.sv ----
// types shared by the dual timer control block
// assumes the constants header is included by each module that needs it
package dtc_pkg;

    typedef enum logic [1:0] {
        dtc_mode_13bit,
        dtc_mode_16bit,
        dtc_mode_auto8,
        dtc_mode_split
    } dtc_mode_e;

    typedef enum logic [1:0] {
        dtc_pre_div12,
        dtc_pre_div4,
        dtc_pre_div48,
        dtc_pre_ext8
    } dtc_pre_e;

    // special-function access from the core, same clock
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic bit_wr;
        logic bit_val;
    } dtc_sfr_req_s;

    // one-cycle vectoring acknowledges from the interrupt logic
    typedef struct packed {
        logic timer0_ack;
        logic timer1_ack;
        logic ext_irq0_ack;
        logic ext_irq1_ack;
    } dtc_vec_s;

    // settings held by the clock control and ext irq config registers
    typedef struct packed {
        logic [1:0] prescale_select;
        logic timer0_clock_select;
        logic timer1_clock_select;
        logic ext_irq0_polarity;
        logic ext_irq1_polarity;
    } dtc_cfg_s;

endpackage

// ---- verilog/dtc_pin_sync.sv ----
// two-flop synchroniser with edge detection for a group of pins
// assumes pins are asynchronous to ref_clk; ce freezes all state
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    // synchronised level and edges
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (ce) begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // successive samples compared once, so one edge gives one pulse
    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// ---- test/dtc_pin_model.sv ----
// far-side model: count pins and external interrupt/gate inputs
// assumes the bench calls its tasks; pins change 1 ns after ref_clk rises
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    // clock
    input wire logic ref_clk,
    // pins
    output logic timer0_count_pin,
    output logic timer1_count_pin,
    output logic ext_irq0_input,
    output logic ext_irq1_input
);
    initial begin
        timer0_count_pin = 1'b1;
        timer1_count_pin = 1'b1;
        ext_irq0_input = 1'b0;
        ext_irq1_input = 1'b0;
    end
    // n falling transitions, each held three cycles so none is missed
    task automatic pulse(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (idx == 0) timer0_count_pin = 1'b0;
            else timer1_count_pin = 1'b0;
            repeat (3) @(posedge ref_clk);
            #1;
            if (idx == 0) timer0_count_pin = 1'b1;
            else timer1_count_pin = 1'b1;
            repeat (3) @(posedge ref_clk);
        end
    endtask
    task automatic set_irq(input int idx, input logic val);
        @(posedge ref_clk);
        #1;
        if (idx == 0) ext_irq0_input = val;
        else ext_irq1_input = val;
    endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the dual timer control block
// assumes the pin model file is compiled first; one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dtc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    dtc_sfr_req_s req = '0;
    dtc_vec_s ack = '0;
    dtc_cfg_s cfg = '0;
    logic [7:0] rdata, status, mode, v;
    logic t0_pin, t1_pin, irq0, irq1, tick0, tick1;
    int err_count = 0;
    int check_count = 0;
    int tick0_count = 0;
    int tick1_count = 0;
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (tick0 === 1'b1) tick0_count++;
    always @(posedge ref_clk) if (tick1 === 1'b1) tick1_count++;
    dtc_pin_model pins (.ref_clk(ref_clk), .timer0_count_pin(t0_pin),
        .timer1_count_pin(t1_pin), .ext_irq0_input(irq0),
        .ext_irq1_input(irq1));
    dtc_timer_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .ce(1'b1),
        .sfr_req(req), .sfr_rdata(rdata), .vec_ack(ack), .cfg(cfg),
        .timer0_count_pin(t0_pin), .timer1_count_pin(t1_pin),
        .ext_irq0_input(irq0), .ext_irq1_input(irq1), .ext_clk_in(1'b0),
        .timer_control_status(status), .timer_mode_select(mode),
        .timer0_overflow_tick(tick0), .timer1_overflow_tick(tick1));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        req = '0;
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(posedge ref_clk);
        #1;
        req = '0;
    endtask
    task automatic bw(input logic [7:0] a, input logic b);
        @(posedge ref_clk);
        #1;
        req = '0;
        req.addr = a;
        req.bit_val = b;
        req.bit_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        req = '0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        req = '0;
        req.addr = a;
        req.rd = 1'b1;
        @(posedge ref_clk);
        #1;
        req = '0;
        chk(rdata, exp);
    endtask
    task automatic vec(input int k);
        @(posedge ref_clk);
        #1;
        ack = '0;
        if (k == 0) ack.timer0_ack = 1'b1;
        if (k == 1) ack.timer1_ack = 1'b1;
        if (k == 2) ack.ext_irq0_ack = 1'b1;
        if (k == 3) ack.ext_irq1_ack = 1'b1;
        @(posedge ref_clk);
        #1;
        ack = '0;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end
    initial begin
        cfg.ext_irq0_polarity = 1'b1;
        cfg.ext_irq1_polarity = 1'b1;
        waitc(10);
        reset = 1'b0;
        rc(8'h88, 8'h00);
        rc(8'h89, 8'h00);
        wr(8'h89, 8'hA5);
        chk(mode, 8'hA5);
        rc(8'h89, 8'hA5);
        wr(8'h88, 8'h5A);
        rc(8'h88, 8'h5A);
        rc(8'h90, 8'h00);
        wr(8'h88, 8'h00);
        bw(8'h8A, 1'b1);
        chk(status, 8'h04);
        wr(8'h88, 8'h00);
        $display("test registers done");
        cfg.timer0_clock_select = 1'b1;
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'hFF);
        wr(8'h89, 8'h01);
        bw(8'h8C, 1'b1);
        waitc(8);
        chk(status, 8'h30);
        chk(tick0_count > 0, 1'b1);
        bw(8'h8C, 1'b0);
        vec(0);
        chk(status, 8'h00);
        wr(8'h8A, 8'h55);
        rc(8'h8A, 8'h55);
        waitc(5);
        rc(8'h8A, 8'h55);
        $display("test timer0 16-bit done");
        cfg.timer0_clock_select = 1'b0;
        wr(8'h89, 8'h06);
        wr(8'h8C, 8'hF0);
        wr(8'h8A, 8'hFE);
        bw(8'h8C, 1'b1);
        pins.pulse(0, 1);
        rc(8'h8A, 8'hFF);
        chk(status, 8'h10);
        pins.pulse(0, 1);
        chk(status, 8'h30);
        rc(8'h8A, 8'hF0);
        rc(8'h8C, 8'hF0);
        pins.pulse(0, 3);
        rc(8'h8A, 8'hF3);
        $display("test auto-reload done");
        wr(8'h88, 8'h10);
        chk(status, 8'h10);
        wr(8'h89, 8'h0E);
        pins.pulse(0, 2);
        rc(8'h8A, 8'hF3);
        pins.set_irq(0, 1'b1);
        pins.pulse(0, 2);
        rc(8'h8A, 8'hF5);
        pins.set_irq(0, 1'b0);
        waitc(4);
        $display("test gate done");
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h04);
        wr(8'h8C, 8'hFF);
        wr(8'h8A, 8'h1E);
        bw(8'h8C, 1'b1);
        pins.pulse(0, 1);
        rc(8'h8A, 8'h1F);
        chk(status, 8'h10);
        pins.pulse(0, 1);
        rc(8'h8A, 8'h00);
        rc(8'h8C, 8'h00);
        chk(status, 8'h30);
        $display("test 13-bit done");
        wr(8'h88, 8'h01);
        pins.set_irq(0, 1'b1);
        waitc(6);
        chk(status, 8'h03);
        vec(2);
        waitc(3);
        chk(status, 8'h01);
        pins.set_irq(0, 1'b0);
        wr(8'h88, 8'h00);
        pins.set_irq(1, 1'b1);
        waitc(6);
        chk(status, 8'h08);
        vec(3);
        chk(status, 8'h08);
        pins.set_irq(1, 1'b0);
        waitc(4);
        wr(8'h88, 8'h00);
        chk(status, 8'h00);
        $display("test external interrupts done");
        wr(8'h89, 8'h70);
        wr(8'h8B, 8'hFE);
        wr(8'h8D, 8'hFF);
        bw(8'h8E, 1'b1);
        pins.pulse(1, 2);
        rc(8'h8B, 8'hFE);
        wr(8'h89, 8'h50);
        chk(mode, 8'h50);
        pins.pulse(1, 2);
        rc(8'h8B, 8'h00);
        rc(8'h8D, 8'h00);
        chk(status, 8'hC0);
        chk(8'(tick1_count), 8'h01);
        vec(1);
        chk(status, 8'h40);
        $display("test timer1 done");
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h03);
        cfg.timer0_clock_select = 1'b1;
        wr(8'h8C, 8'hFE);
        waitc(6);
        chk(status, 8'h00);
        bw(8'h8E, 1'b1);
        waitc(8);
        chk(status, 8'hC0);
        rc(8'h8A, 8'h00);
        $display("test split mode done");
        report_and_stop();
    end
endmodule
`default_nettype wire
